// ### logic/srx_pkg.sv
// package: constants and carrier types for the subroutine-return execution block
package srx_pkg;

  // =====================================================================
  // instruction word layout, default pc width and stack depth, accumulator reset value
  localparam int unsigned INSN_W = 14;
  localparam int unsigned LIT_W = 8;
  localparam int unsigned PC_W_DEF = 13;
  localparam int unsigned STACK_DEPTH_DEF = 8;
  localparam logic [3:0] RETLIT_TOP = 4'hD;
  localparam logic [13:0] RETURN_OPC = 14'h0008;
  localparam logic [7:0] ACC_RESET = 8'h00;

  // =====================================================================
  // quarter-phase timing: four core clocks make one instruction cycle
  localparam logic [1:0] PH_DECODE = 2'h0;
  localparam logic [1:0] PH_READ = 2'h1;
  localparam logic [1:0] PH_PROCESS = 2'h2;
  localparam logic [1:0] PH_WRITE = 2'h3;

  // =====================================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic [13:0] word;
  } srx_insn_t;

  typedef struct packed {
    logic push;
    logic [12:0] addr;
  } srx_call_t;

  typedef enum logic [1:0] {
    SRX_RUN = 2'b00,
    SRX_RET1 = 2'b01,
    SRX_IDLE2 = 2'b10
  } srx_state_t;

endpackage

// ### logic/srx_return_exec.sv
// module: executes the plain return and the return-with-immediate instructions
`timescale 1ns/1ps

// Overview of operation
// [RQ1] return_with_immediate opcode 11 01xx kkkk kkkk copies k into the accumulator.
// [RQ2] return_with_immediate pops the call stack and loads pc with stack_top_entry.
// [RQ3] return_with_immediate lasts two instruction cycles; the second does nothing.
// [RQ4] plain return opcode 0x0008 pops the stack into the program counter.
// [RQ5] plain return takes two cycles; pop in last phase of first; second idle.
// [RQ6] the prefetched word is flushed; fetch resumes at the restored pc.
module srx_return_exec #(
  parameter int unsigned PC_W = srx_pkg::PC_W_DEF,
  parameter int unsigned DEPTH = srx_pkg::STACK_DEPTH_DEF
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire srx_pkg::srx_insn_t i_insn,
  input wire srx_pkg::srx_call_t i_call,
  output logic [7:0] o_acc,
  output logic [PC_W-1:0] o_pc_load,
  output logic o_pc_load_en,
  output logic o_flush,
  output logic o_busy,
  output logic [1:0] o_phase
);

  localparam int unsigned SP_W = $clog2(DEPTH);

  // =====================================================================
  // helpers
  // both decoders feed the state machine; the immediate one also feeds the operand latch; one
  // definition keeps the two readings of the word from drifting apart
  function automatic logic dec_with_imm(input srx_pkg::srx_insn_t insn);
    dec_with_imm = insn.valid && (insn.word[13:10] == srx_pkg::RETLIT_TOP);
  endfunction

  function automatic logic dec_plain(input srx_pkg::srx_insn_t insn);
    dec_plain = insn.valid && (insn.word == srx_pkg::RETURN_OPC);
  endfunction

  // one step of the stack pointer; it wraps, so an overflow silently
  // overwrites the oldest return address
  function automatic logic [SP_W-1:0] sp_step(input logic [SP_W-1:0] sp, input logic up);
    if (up) begin
      sp_step = sp + SP_W'(1);
    end else begin
      sp_step = sp - SP_W'(1);
    end
  endfunction

  // =====================================================================
  // phase counter: one instruction cycle is four core clocks
  logic [1:0] phase_q;
  wire logic [1:0] phase_d = phase_q + 2'h1;
  wire logic phase_first = (phase_q == srx_pkg::PH_DECODE);
  // one-clock enable that marks the end of each instruction cycle
  wire logic phase_last = (phase_q == srx_pkg::PH_WRITE);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_q <= srx_pkg::PH_DECODE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // =====================================================================
  // decode, taken only in the decode phase of a free cycle
  srx_pkg::srx_state_t state_q;
  srx_pkg::srx_state_t state_d;
  logic lit_q;
  logic [7:0] imm_q;

  wire logic is_retlit = dec_with_imm(i_insn); // [RQ1]
  wire logic is_return = dec_plain(i_insn); // [RQ4]
  // words offered while a return runs are ignored, not queued
  wire logic slot_free = (state_q == srx_pkg::SRX_RUN) && phase_first;
  wire logic start_ret = slot_free && (is_retlit || is_return);

  always_comb begin
    state_d = state_q;
    case (state_q)
      srx_pkg::SRX_RUN: begin
        if (start_ret) begin
          state_d = srx_pkg::SRX_RET1;
        end
      end
      srx_pkg::SRX_RET1: begin
        if (phase_last) begin
          state_d = srx_pkg::SRX_IDLE2; // [RQ3] [RQ5]
        end
      end
      srx_pkg::SRX_IDLE2: begin
        // the second cycle does nothing but run out its four phases
        if (phase_last) begin
          state_d = srx_pkg::SRX_RUN; // [RQ3] [RQ5]
        end
      end
      default: begin
        state_d = srx_pkg::SRX_RUN;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= srx_pkg::SRX_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // =====================================================================
  // operand latch: type and immediate of the word seen in a free decode slot
  wire logic lit_d = slot_free ? is_retlit : lit_q;
  wire logic [7:0] imm_d = slot_free ? i_insn.word[7:0] : imm_q; // [RQ1]

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      lit_q <= 1'b0;
      imm_q <= srx_pkg::ACC_RESET;
    end else begin
      lit_q <= lit_d;
      imm_q <= imm_d;
    end
  end

  // =====================================================================
  // hardware call stack, circular like the real core: overflow wraps silently
  logic [PC_W-1:0] stack_q [DEPTH];
  logic [SP_W-1:0] sp_q;
  // pushes during a return are dropped so the pop always sees a settled pointer
  wire logic push_ok = i_call.push && (state_q == srx_pkg::SRX_RUN);
  wire logic pop_now = (state_q == srx_pkg::SRX_RET1) && phase_last; // [RQ2] [RQ5]
  wire logic [SP_W-1:0] sp_top = sp_step(sp_q, 1'b0);
  wire logic [SP_W-1:0] sp_up = sp_step(sp_q, 1'b1);
  wire logic [SP_W-1:0] sp_d = pop_now ? sp_top : (push_ok ? sp_up : sp_q);
  wire logic [PC_W-1:0] stack_top_entry = stack_q[sp_top]; // [RQ2] [RQ4]
  wire logic [PC_W-1:0] push_addr = i_call.addr[PC_W-1:0];

  // a pop and a push never meet: one needs the return state, the other the run state
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sp_q <= '0;
    end else begin
      sp_q <= sp_d; // [RQ2] [RQ4]
    end
  end

  // no reset on the entries: a return with no matching call yields garbage
  always_ff @(posedge i_core_clk) begin
    if (push_ok) begin
      stack_q[sp_q] <= push_addr;
    end
  end

  // =====================================================================
  // output registers
  logic [7:0] acc_q;
  logic [PC_W-1:0] pc_load_q;
  logic pc_load_en_q;
  logic flush_q;
  logic busy_q;

  // the accumulator and the restored pc hold between returns
  wire logic [7:0] acc_d = (pop_now && lit_q) ? imm_q : acc_q; // [RQ1]
  wire logic [PC_W-1:0] pc_load_d = pop_now ? stack_top_entry : pc_load_q; // [RQ2] [RQ4]
  // busy follows the next state so that it rises on the taking edge itself
  wire logic busy_d = (state_d != srx_pkg::SRX_RUN); // [RQ3] [RQ5]

  // only the immediate form writes the accumulator; a plain return leaves it alone
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_q <= srx_pkg::ACC_RESET;
    end else begin
      acc_q <= acc_d; // [RQ1]
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pc_load_q <= '0;
    end else begin
      pc_load_q <= pc_load_d; // [RQ2] [RQ4]
    end
  end

  // one-clock strobe: the pc takes o_pc_load while it is high
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pc_load_en_q <= 1'b0;
    end else begin
      pc_load_en_q <= pop_now; // [RQ2] [RQ4]
    end
  end

  // the word prefetched during the return is dropped; fetch restarts at o_pc_load
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      flush_q <= 1'b0;
    end else begin
      flush_q <= pop_now; // [RQ6]
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d; // [RQ3] [RQ5]
    end
  end

  // the phase counter is itself a register, so it leaves the block directly
  assign o_acc = acc_q;
  assign o_pc_load = pc_load_q;
  assign o_pc_load_en = pc_load_en_q;
  assign o_flush = flush_q; // [RQ6]
  assign o_busy = busy_q;
  assign o_phase = phase_q;

endmodule

// ### bench/srx_return_exec_assertions.sv
// checker: port timing of the return block
`timescale 1ns/1ps
module srx_assertions (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire srx_pkg::srx_insn_t i_insn,
  input wire logic [7:0] o_acc,
  input wire logic o_pc_load_en,
  input wire logic o_flush,
  input wire logic o_busy,
  input wire logic [1:0] o_phase
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire [7:0] k = i_insn.word[7:0];
  wire lit = i_insn.word[13:10] == srx_pkg::RETLIT_TOP;
  wire take = i_insn.valid && o_phase == 2'h0 && !o_busy
    && (lit || i_insn.word == srx_pkg::RETURN_OPC);
  sequence s_take; take; endsequence
  sequence s_pop; ##4 o_pc_load_en ##1 !o_pc_load_en; endsequence
  sequence s_first_cycle; (o_busy && !o_pc_load_en)[*3] ##1 (o_busy && o_pc_load_en); endsequence
  sequence s_idle_cycle; (o_busy && !o_pc_load_en)[*3] ##1 !o_busy; endsequence
  // ====
  // the pop strobe and the accumulator are sampled four edges after the taking edge; busy is followed over eight
  pop_pulse_a: assert property (s_take |-> s_pop) else $error("pop");
  acc_load_a: assert property (s_take ##0 lit |-> ##4 o_acc == $past(k, 4))
    else $error("acc");
  idle_slot_a: assert property (s_take |=> s_first_cycle ##1 s_idle_cycle)
    else $error("idle");
  acc_keep_a: assert property (s_take ##0 !lit |-> ##4 $stable(o_acc)) else $error("keep");
  pop_phase_a: assert property (o_pc_load_en |-> o_phase == srx_pkg::PH_DECODE)
    else $error("phase");
  pop_cause_a: assert property ($rose(o_pc_load_en) |-> $past(take, 4))
    else $error("cause");
  flush_pair_a: assert property (o_flush == o_pc_load_en) else $error("flush");
endmodule
bind srx_return_exec srx_assertions chk_u (
  .i_core_clk(i_core_clk),
  .i_rst(i_rst),
  .i_insn(i_insn),
  .o_acc(o_acc),
  .o_pc_load_en(o_pc_load_en),
  .o_flush(o_flush),
  .o_busy(o_busy),
  .o_phase(o_phase)
);

// ### bench/srx_return_exec_tb.sv
// bench for the return block
`timescale 1ns/1ps
module srx_return_exec_tb;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  srx_pkg::srx_insn_t i_insn = '0;
  srx_pkg::srx_call_t i_call = '0;
  logic [7:0] o_acc;
  logic [12:0] o_pc_load;
  logic o_pc_load_en, o_flush, o_busy;
  logic [1:0] o_phase;
  int err_total = 0, checks_done = 0, cyc = 0;
  srx_return_exec dut_u (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_insn(i_insn),
    .i_call(i_call),
    .o_acc(o_acc),
    .o_pc_load(o_pc_load),
    .o_pc_load_en(o_pc_load_en),
    .o_flush(o_flush),
    .o_busy(o_busy),
    .o_phase(o_phase)
  );
  initial forever #5 i_core_clk = ~i_core_clk;
  task chk(input logic [23:0] seen, exp);
    checks_done++;
    if (seen !== exp) err_total++;
    if (seen !== exp) $display("[ERR] %0t got %h want %h", $time, seen, exp);
  endtask
  task complete_run();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ====
  // waits for a free decode slot; returns just after the pop edge, the third after taking
  task issue(input logic [13:0] w);
    do @(posedge i_core_clk) #1; while (o_phase !== 2'h3 || o_busy !== 1'b0);
    @(posedge i_core_clk) i_insn <= {1'b1, w};
    @(posedge i_core_clk) i_insn <= '0;
    repeat (3) @(posedge i_core_clk);
    #1;
  endtask
  task sc_literal();
    for (int n = 1; n < 4; n++) begin
      @(posedge i_core_clk) i_call <= {1'b1, 13'(n * 13'h0A5)};
      @(posedge i_core_clk) i_call <= '0;
    end
    issue(14'h345A);
    chk({o_acc, o_pc_load_en, o_flush, 1'b0, o_pc_load}, 24'h5AC1EF);
    issue(14'h37FF);
    chk({o_acc, 3'h0, o_pc_load}, 24'hFF014A);
    @(posedge i_core_clk) #1;
    chk({o_busy, o_pc_load_en}, 24'h2);
  endtask
  task sc_plain();
    issue(14'h0009);
    chk({o_busy, o_pc_load_en}, 24'h0);
    issue(14'h0008);
    chk({o_acc, o_busy, o_pc_load_en, o_flush, o_pc_load}, 24'hFFE0A5);
  endtask
  initial begin
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    sc_literal();
    sc_plain();
    complete_run();
  end
  always @(posedge i_core_clk) begin
    if (++cyc == 500) begin
      err_total++;
      complete_run();
    end
  end
endmodule
